// file: afc_frame_clk_mon.sv
// frame sync generation and clock error monitoring for both serial ports, apb register slave
//
// Summary of operation
// - primary sync counts internal or external bit clock
// - secondary sync counts internal or external bit clock
// - primary inversion affects frame-sync counting and ratio measuring only
// - secondary inversion affects frame-sync counting and ratio measuring only
// - primary ratio is six high plus eight low
// - secondary ratio is six high plus eight low
// - processing error flags any port or reference ratio
// - converter ratio flag, ignored under custom ratio
// - matching rate flag mirrors clock configuration fault
// - pdm clock flag mirrors clock configuration fault
// - clock-stop flag after one millisecond without edges
// - primary ratio error flag
// - secondary ratio error flag
// - reference clock to frame ratio error flag
// - primary frame rate change or halt flag
// - secondary frame rate change or halt flag
// - status registers read-only, zero after reset
// - primary controller select enables its generation
// - secondary controller select enables its generation
//
// The APB register port was decided locally.
`timescale 1ns/1ps

module afc_frame_clk_mon
  import afc_pkg::*;
#(
  parameter logic [15:0] P_STOP_CYC = 16'(STOP_CYC),
  parameter logic [15:0] P_HALT_CYC = 16'(HALT_CYC)
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // serial port pins
  input  wire logic              i_pri_bclk,
  input  wire logic              i_sec_bclk,
  input  wire logic              i_pri_fsync,
  input  wire logic              i_sec_fsync,
  output logic                   o_pri_fsync,
  output logic                   o_pri_fsync_oe,
  output logic                   o_sec_fsync,
  output logic                   o_sec_fsync_oe,
  // clock pins under watch
  input  wire logic              i_ref_clk,
  input  wire logic              i_audio_clk,
  // same-domain fault inputs from the clock tree
  input  wire logic              i_converter_ratio_bad,
  input  wire logic              i_custom_ratio,
  input  wire logic              i_matching_rate_bad,
  input  wire logic              i_pdm_clock_bad
);

  afc_state_s state_reg;
  afc_state_s state_next;
  logic [1:0] edge_w;
  logic [1:0] fsrise_w;

  always_comb begin : comb
    logic        sel;
    logic        fs_now;
    logic        wrap;
    logic [15:0] diff;
    logic [7:0]  rd;
    logic [5:0]  idx;
    logic        hit;
    logic [1:0]  bclk_pin;
    logic [1:0]  fs_pin;
    logic        ref_edge;
    sel        = 1'b0;
    fs_now     = 1'b0;
    wrap       = 1'b0;
    diff       = '0;
    rd         = RST_BYTE;
    idx        = i_paddr[ADDR_W-1:2];
    hit        = 1'b0;
    bclk_pin   = {i_sec_bclk, i_pri_bclk};
    fs_pin     = {i_sec_fsync, i_pri_fsync};
    ref_edge   = 1'b0;
    state_next = state_reg;
    edge_w     = '0;
    fsrise_w   = '0;

    // internal bit clock, a plain divider of the master clock
    if (state_reg.div_cnt == INT_BCLK_HALF - 4'h1) begin
      state_next.div_cnt  = '0;
      state_next.int_bclk = ~state_reg.int_bclk;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 4'h1;
    end

    for (int p = 0; p < 2; p++) begin
      state_next.port[p].bclk_s1 = bclk_pin[p];
      state_next.port[p].bclk_s2 = state_reg.port[p].bclk_s1;
      state_next.port[p].fs_s1   = fs_pin[p];
      state_next.port[p].fs_s2   = state_reg.port[p].fs_s1;

      // source choice and inversion feed only the frame counter and the ratio measure counter
      sel = (state_reg.port[p].int_sel ? state_reg.int_bclk
                                       : state_reg.port[p].bclk_s2)
            ^ state_reg.port[p].inv;
      state_next.port[p].sel_q = sel;
      edge_w[p] = sel & ~state_reg.port[p].sel_q;

      if (state_reg.port[p].ctrl) begin
        if (edge_w[p]) begin
          wrap = ({2'b00, state_reg.port[p].bit_cnt} + 16'h0001)
                 >= {2'b00, state_reg.port[p].ratio};
          state_next.port[p].bit_cnt = wrap ? '0 : state_reg.port[p].bit_cnt + 14'h0001;
        end
        state_next.port[p].fs_out = (state_next.port[p].bit_cnt == '0);
      end else begin
        state_next.port[p].bit_cnt = '0;
        state_next.port[p].fs_out  = 1'b0;
      end

      // frame observed: own sync as controller, pin sync as target
      fs_now = state_reg.port[p].ctrl ? state_reg.port[p].fs_out : state_reg.port[p].fs_s2;
      state_next.port[p].fs_obs_q = fs_now;
      fsrise_w[p] = fs_now & ~state_reg.port[p].fs_obs_q;

      if (edge_w[p] && state_reg.port[p].meas_cnt != '1) begin
        state_next.port[p].meas_cnt = state_reg.port[p].meas_cnt + 14'h0001;
      end
      if (state_reg.port[p].len_cnt != P_HALT_CYC) begin
        state_next.port[p].len_cnt = state_reg.port[p].len_cnt + 16'h0001;
      end

      if (fsrise_w[p]) begin
        if (!state_reg.port[p].ctrl) begin
          state_next.port[p].ratio_err = (state_reg.port[p].ratio != '0) &&
            (state_reg.port[p].meas_cnt != state_reg.port[p].ratio);
        end
        state_next.port[p].meas_cnt = '0;
        diff = (state_reg.port[p].len_cnt >= state_reg.port[p].prev_len)
               ? state_reg.port[p].len_cnt - state_reg.port[p].prev_len
               : state_reg.port[p].prev_len - state_reg.port[p].len_cnt;
        state_next.port[p].rate_err = (state_reg.port[p].prev_len != '0) &&
                                      (diff > RATE_TOL);
        state_next.port[p].prev_len = state_reg.port[p].len_cnt;
        state_next.port[p].len_cnt  = '0;
      end else if (state_reg.port[p].len_cnt == P_HALT_CYC) begin
        // a halted frame sync; the next frame starts a fresh comparison
        state_next.port[p].rate_err = 1'b1;
        state_next.port[p].prev_len = '0;
      end

      // as controller the sync follows the count, so only a ratio below two is wrong
      if (state_reg.port[p].ctrl) begin
        state_next.port[p].ratio_err = (state_reg.port[p].ratio < RATIO_MIN);
      end
    end

    // reference clock edges per primary frame must stay steady
    state_next.ref_s1 = i_ref_clk;
    state_next.ref_s2 = state_reg.ref_s1;
    state_next.ref_q  = state_reg.ref_s2;
    ref_edge = state_reg.ref_s2 & ~state_reg.ref_q;
    if (ref_edge && state_reg.ref_cnt != '1) begin
      state_next.ref_cnt = state_reg.ref_cnt + 16'h0001;
    end
    if (fsrise_w[0]) begin
      diff = (state_reg.ref_cnt >= state_reg.ref_prev)
             ? state_reg.ref_cnt - state_reg.ref_prev
             : state_reg.ref_prev - state_reg.ref_cnt;
      state_next.ref_err  = (state_reg.ref_cnt == '0) ||
                            ((state_reg.ref_prev != '0) && (diff > REF_TOL));
      state_next.ref_prev = state_reg.ref_cnt;
      state_next.ref_cnt  = '0;
    end

    // audio clock stop watch
    state_next.aud_s1 = i_audio_clk;
    state_next.aud_s2 = state_reg.aud_s1;
    state_next.aud_q  = state_reg.aud_s2;
    if (state_reg.aud_s2 != state_reg.aud_q) begin
      state_next.stop_cnt  = '0;
      state_next.stop_flag = 1'b0;
    end else if (state_reg.stop_cnt != P_STOP_CYC) begin
      state_next.stop_cnt = state_reg.stop_cnt + 16'h0001;
    end else begin
      state_next.stop_flag = 1'b1;
    end

    state_next.proc_err  = state_reg.port[0].ratio_err | state_reg.port[1].ratio_err
                           | state_reg.ref_err;
    state_next.conv_err  = i_converter_ratio_bad & ~i_custom_ratio;
    state_next.match_err = i_matching_rate_bad;
    state_next.pdm_err   = i_pdm_clock_bad;

    // apb: data and ready are prepared in the setup cycle, so every transfer takes one wait-free
    // access cycle and all outputs come from flops
    unique case (idx)
      IDX_CTRL_CFG: begin
        hit = 1'b1;
        rd[CTRL_PRI_BIT] = state_reg.port[0].ctrl;
        rd[CTRL_SEC_BIT] = state_reg.port[1].ctrl;
      end
      IDX_PRI_CFG: begin
        hit = 1'b1;
        rd  = {state_reg.port[0].int_sel, state_reg.port[0].inv,
               state_reg.port[0].ratio[13:8]};
      end
      IDX_PRI_LOW: begin
        hit = 1'b1;
        rd  = state_reg.port[0].ratio[7:0];
      end
      IDX_SEC_CFG: begin
        hit = 1'b1;
        rd  = {state_reg.port[1].int_sel, state_reg.port[1].inv,
               state_reg.port[1].ratio[13:8]};
      end
      IDX_SEC_LOW: begin
        hit = 1'b1;
        rd  = state_reg.port[1].ratio[7:0];
      end
      IDX_STS_A: begin
        hit = 1'b1;
        rd[STSA_PROC_BIT]  = state_reg.proc_err;
        rd[STSA_CONV_BIT]  = state_reg.conv_err;
        rd[STSA_MATCH_BIT] = state_reg.match_err;
        rd[STSA_PDM_BIT]   = state_reg.pdm_err;
        rd[STSA_STOP_BIT]  = state_reg.stop_flag;
      end
      IDX_STS_B: begin
        hit = 1'b1;
        rd[STSB_PRAT_BIT]  = state_reg.port[0].ratio_err;
        rd[STSB_SRAT_BIT]  = state_reg.port[1].ratio_err;
        rd[STSB_REF_BIT]   = state_reg.ref_err;
        rd[STSB_PRATE_BIT] = state_reg.port[0].rate_err;
        rd[STSB_SRATE_BIT] = state_reg.port[1].rate_err;
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !hit || (i_paddr[1:0] != 2'b00);
      state_next.prdata  = (hit && !i_pwrite) ? rd : RST_BYTE;
    end

    // writes land at the access edge; status registers ignore them
    if (i_psel && i_penable && state_reg.pready && i_pwrite && i_pstrb[0]
        && !state_reg.pslverr) begin
      unique case (idx)
        IDX_CTRL_CFG: begin
          state_next.port[0].ctrl = i_pwdata[CTRL_PRI_BIT];
          state_next.port[1].ctrl = i_pwdata[CTRL_SEC_BIT];
        end
        IDX_PRI_CFG: begin
          state_next.port[0].int_sel     = i_pwdata[CFG_INT_BIT];
          state_next.port[0].inv         = i_pwdata[CFG_INV_BIT];
          state_next.port[0].ratio[13:8] = i_pwdata[CFG_HIGH_MSB:0];
        end
        IDX_PRI_LOW: state_next.port[0].ratio[7:0] = i_pwdata[7:0];
        IDX_SEC_CFG: begin
          state_next.port[1].int_sel     = i_pwdata[CFG_INT_BIT];
          state_next.port[1].inv         = i_pwdata[CFG_INV_BIT];
          state_next.port[1].ratio[13:8] = i_pwdata[CFG_HIGH_MSB:0];
        end
        IDX_SEC_LOW: state_next.port[1].ratio[7:0] = i_pwdata[7:0];
        default: begin
          state_next.pslverr = state_next.pslverr;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_prdata       = {24'h000000, state_reg.prdata};
  assign o_pready       = state_reg.pready;
  assign o_pslverr      = state_reg.pslverr;
  assign o_pri_fsync    = state_reg.port[0].fs_out;
  assign o_pri_fsync_oe = state_reg.port[0].ctrl;
  assign o_sec_fsync    = state_reg.port[1].fs_out;
  assign o_sec_fsync_oe = state_reg.port[1].ctrl;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_pri_ext_src: assert property (
    (state_reg.port[0].ctrl && !state_reg.port[0].int_sel && !state_reg.port[0].inv
     && $stable(state_reg.port[0].int_sel) && $stable(state_reg.port[0].inv)
     && state_reg.port[0].bclk_s2 && !$past(state_reg.port[0].bclk_s2)) |-> edge_w[0])
    else $error("primary frame counter missed an external bit clock edge");

  chk_pri_inv_edge: assert property (
    (state_reg.port[0].ctrl && !state_reg.port[0].int_sel && state_reg.port[0].inv
     && $stable(state_reg.port[0].int_sel) && $stable(state_reg.port[0].inv)
     && !state_reg.port[0].bclk_s2 && $past(state_reg.port[0].bclk_s2)) |-> edge_w[0])
    else $error("primary inverted clock did not count the falling edge");

  chk_sec_int_src: assert property (
    (state_reg.port[1].int_sel && !state_reg.port[1].inv
     && $stable(state_reg.port[1].int_sel) && $stable(state_reg.port[1].inv))
    |-> (edge_w[1] == (state_reg.int_bclk && !$past(state_reg.int_bclk))))
    else $error("secondary frame counter not following internal bit clock");

  chk_frame_count: assert property (
    (state_reg.port[0].ctrl && edge_w[0] && state_reg.port[0].ratio >= RATIO_MIN
     && $stable(state_reg.port[0].ctrl))
    |=> (state_reg.port[0].bit_cnt != $past(state_reg.port[0].bit_cnt)))
    else $error("primary frame counter did not advance on a bit clock edge");

  chk_target_quiet: assert property (
    (!state_reg.port[1].ctrl && !$past(state_reg.port[1].ctrl))
    |-> (!o_sec_fsync && !o_sec_fsync_oe))
    else $error("secondary port drives frame sync while target");

  chk_small_ratio: assert property (
    (state_reg.port[0].ctrl && state_reg.port[0].ratio < RATIO_MIN)[*2]
    |=> state_reg.port[0].ratio_err ##1 state_reg.proc_err)
    else $error("ratio below two not flagged");

  chk_stop_flag: assert property (
    (state_reg.stop_cnt == P_STOP_CYC && state_reg.aud_s2 == state_reg.aud_q)
    |=> state_reg.stop_flag)
    else $error("clock stop not flagged after the stop count");

  chk_conv_custom: assert property (
    i_custom_ratio |=> !state_reg.conv_err)
    else $error("converter ratio flag set under custom ratio");

  chk_apb_ready: assert property (
    (i_psel && !i_penable) |=> (o_pready ##1 !o_pready))
    else $error("apb ready not a single cycle after setup");

endmodule : afc_frame_clk_mon

// file: afc_host_model.sv
// host audio processor model: bit clocks, target frame syncs, reference and audio clocks
`timescale 1ns/1ps

module afc_host_model (
  // run controls from the bench
  input  wire logic [1:0] i_bclk_run,
  input  wire logic [1:0] i_fs_run,
  input  wire logic [7:0] i_fs_len0,
  input  wire logic [7:0] i_fs_len1,
  input  wire logic       i_ref_run,
  input  wire logic       i_aud_run,
  // pins toward the device
  output logic      [1:0] o_bclk,
  output logic      [1:0] o_fsync,
  output logic            o_ref_clk,
  output logic            o_aud_clk
);
  logic [7:0] cnt [2];
  logic [7:0] len;

  // odd start offset keeps the link clock unrelated in phase to the bench clock
  initial begin
    o_bclk = 2'b00;
    o_fsync = 2'b00;
    cnt[0] = 8'h00;
    cnt[1] = 8'h00;
    #37;
    forever begin
      #200;
      for (int p = 0; p < 2; p++) begin
        len = (p == 0) ? i_fs_len0 : i_fs_len1;
        // a stopped bit clock holds its last level and freezes the frame
        if (i_bclk_run[p]) begin
          o_bclk[p] = ~o_bclk[p];
          // sync moves on the falling edge so the device sees it stable when sampling
          if (!o_bclk[p]) begin
            cnt[p] = (cnt[p] + 8'h01 >= len) ? 8'h00 : cnt[p] + 8'h01;
            o_fsync[p] = i_fs_run[p] && (cnt[p] == 8'h00);
          end
        end
      end
    end
  end

  initial begin
    o_ref_clk = 1'b0;
    #11;
    forever begin
      #150;
      if (i_ref_run) o_ref_clk = ~o_ref_clk;
    end
  end

  initial begin
    o_aud_clk = 1'b0;
    forever begin
      #130;
      if (i_aud_run) o_aud_clk = ~o_aud_clk;
    end
  end
endmodule : afc_host_model

// file: afc_pkg.sv
// constants, register map and state layout of the frame clock generator and error monitor
package afc_pkg;

  // timing
  localparam int unsigned CLK_MHZ      = 20;
  localparam int unsigned STOP_TIME_US = 1000;
  localparam int unsigned STOP_CYC     = STOP_TIME_US * CLK_MHZ;
  localparam int unsigned HALT_TIME_US = 1000;
  localparam int unsigned HALT_CYC     = HALT_TIME_US * CLK_MHZ;
  localparam logic [3:0]  INT_BCLK_HALF = 4'h2;
  localparam logic [15:0] RATE_TOL      = 16'h0004;
  localparam logic [15:0] REF_TOL       = 16'h0001;
  localparam logic [13:0] RATIO_MIN     = 14'h0002;

  // register indices; byte address is four times the index
  localparam int unsigned ADDR_W        = 8;
  localparam logic [5:0]  IDX_CTRL_CFG  = 6'h37;
  localparam logic [5:0]  IDX_PRI_CFG   = 6'h38;
  localparam logic [5:0]  IDX_PRI_LOW   = 6'h39;
  localparam logic [5:0]  IDX_SEC_CFG   = 6'h3A;
  localparam logic [5:0]  IDX_SEC_LOW   = 6'h3B;
  localparam logic [5:0]  IDX_STS_A     = 6'h3C;
  localparam logic [5:0]  IDX_STS_B     = 6'h3D;

  // field positions
  localparam int unsigned CTRL_PRI_BIT   = 4;
  localparam int unsigned CTRL_SEC_BIT   = 3;
  localparam int unsigned CFG_INT_BIT    = 7;
  localparam int unsigned CFG_INV_BIT    = 6;
  localparam int unsigned CFG_HIGH_MSB   = 5;
  localparam int unsigned STSA_PROC_BIT  = 7;
  localparam int unsigned STSA_CONV_BIT  = 4;
  localparam int unsigned STSA_MATCH_BIT = 3;
  localparam int unsigned STSA_PDM_BIT   = 2;
  localparam int unsigned STSA_STOP_BIT  = 1;
  localparam int unsigned STSB_PRAT_BIT  = 7;
  localparam int unsigned STSB_SRAT_BIT  = 6;
  localparam int unsigned STSB_REF_BIT   = 5;
  localparam int unsigned STSB_PRATE_BIT = 4;
  localparam int unsigned STSB_SRATE_BIT = 3;
  localparam logic [7:0]  RST_BYTE       = 8'h00;

  // per-port state
  typedef struct packed {
    logic        bclk_s1;
    logic        bclk_s2;
    logic        fs_s1;
    logic        fs_s2;
    logic        sel_q;
    logic        fs_obs_q;
    logic        int_sel;
    logic        inv;
    logic        ctrl;
    logic [13:0] ratio;
    logic [13:0] bit_cnt;
    logic        fs_out;
    logic [13:0] meas_cnt;
    logic [15:0] len_cnt;
    logic [15:0] prev_len;
    logic        ratio_err;
    logic        rate_err;
  } afc_port_s;

  // whole block state
  typedef struct packed {
    afc_port_s [1:0] port;
    logic [3:0]      div_cnt;
    logic            int_bclk;
    logic            ref_s1;
    logic            ref_s2;
    logic            ref_q;
    logic [15:0]     ref_cnt;
    logic [15:0]     ref_prev;
    logic            ref_err;
    logic            aud_s1;
    logic            aud_s2;
    logic            aud_q;
    logic [15:0]     stop_cnt;
    logic            stop_flag;
    logic            proc_err;
    logic            conv_err;
    logic            match_err;
    logic            pdm_err;
    logic [7:0]      prdata;
    logic            pready;
    logic            pslverr;
  } afc_state_s;

  localparam afc_state_s STATE_RST = '0;

endpackage : afc_pkg

// file: tb_afc_frame_clk_mon.sv
// self-checking bench for the frame clock generator and clock error monitor
`timescale 1ns/1ps

`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: %s", $time, msg); end end

module tb_afc_frame_clk_mon;
  import afc_pkg::*;
  localparam logic [15:0] STOP_N = 16'h0040;
  localparam logic [15:0] HALT_N = 16'h00C8;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  wire  [1:0]  bclk, fs_in, fs_out, fs_oe;
  wire         ref_clk, aud_clk;
  logic [1:0]  bclk_dly;
  logic [1:0]  bclk_run = 2'b11, fs_run = 2'b11;
  logic        ref_run = 1'b1, aud_run = 1'b1;
  logic        conv_bad = 1'b0, custom = 1'b0, match_bad = 1'b0, pdm_bad = 1'b0;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [5:0]  cfg_idx [2] = '{IDX_PRI_CFG, IDX_SEC_CFG};
  logic [5:0]  low_idx [2] = '{IDX_PRI_LOW, IDX_SEC_LOW};
  logic [7:0]  rat_m [2] = '{8'h80, 8'h40};
  logic [7:0]  rate_m [2] = '{8'h10, 8'h08};
  logic [3:0]  fv [4] = '{4'h8, 4'hC, 4'h2, 4'h1};
  logic [7:0]  fe [4] = '{8'h10, 8'h00, 8'h08, 8'h04};
  logic [7:0]  v;
  logic        e, lvl;
  time         dt, ex;

  always #25 mclk = ~mclk;
  always @(bclk) bclk_dly <= #100 bclk;

  afc_frame_clk_mon #(.P_STOP_CYC(STOP_N), .P_HALT_CYC(HALT_N)) uut (
    .i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pri_bclk(bclk[0]), .i_sec_bclk(bclk[1]),
    .i_pri_fsync(fs_in[0]), .i_sec_fsync(fs_in[1]), .o_pri_fsync(fs_out[0]),
    .o_pri_fsync_oe(fs_oe[0]), .o_sec_fsync(fs_out[1]), .o_sec_fsync_oe(fs_oe[1]),
    .i_ref_clk(ref_clk), .i_audio_clk(aud_clk), .i_converter_ratio_bad(conv_bad),
    .i_custom_ratio(custom), .i_matching_rate_bad(match_bad), .i_pdm_clock_bad(pdm_bad));

  afc_host_model host (
    .i_bclk_run(bclk_run), .i_fs_run(fs_run), .i_fs_len0(8'h08), .i_fs_len1(8'h08),
    .i_ref_run(ref_run), .i_aud_run(aud_run), .o_bclk(bclk), .o_fsync(fs_in),
    .o_ref_clk(ref_clk), .o_aud_clk(aud_clk));

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task hang(input string msg);
    bad_count++;
    $display("mismatch at %0t: %s", $time, msg);
    test_done();
  endtask : hang

  task apb(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd,
           output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    // look at the answer half a cycle before the edge that takes it, where it has settled
    do begin
      @(negedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang("no pready");
    rd = prdata[7:0];
    err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       er;
    apb(1'b1, {idx, 2'b00}, d, r, er);
    `CHK(er, 1'b0, "write refused")
  endtask : wr

  // read until the masked value matches or the tries run out
  task poll(input logic [5:0] idx, input logic [7:0] m, input logic [7:0] x, input int tries,
            input string msg);
    logic [7:0] r;
    logic       er;
    int         k;
    k = 0;
    do begin
      apb(1'b0, {idx, 2'b00}, 8'h00, r, er);
      k++;
    end while (((r & m) !== x) && k < tries);
    `CHK(r & m, x, msg)
  endtask : poll

  // time between the second and third generated sync rises
  task fs_per(input int p, output time d, output logic l);
    time tm [3];
    int  k, n;
    logic prev;
    k = 0;
    n = 0;
    prev = 1'b1;
    while (k < 3 && n < 4000) begin
      @(negedge mclk);
      n++;
      if (fs_out[p] === 1'b1 && prev === 1'b0) begin
        tm[k] = $time;
        l = bclk_dly[p];
        k++;
      end
      prev = fs_out[p];
    end
    if (k < 3) hang("no frame sync");
    d = tm[2] - tm[1];
  endtask : fs_per

  initial begin
    repeat (100000) @(posedge mclk);
    hang("run too long");
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    foreach (cfg_idx[i]) begin
      poll(IDX_STS_A + 6'(i), 8'hFF, 8'h00, 1, "status reset");
      wr(IDX_STS_A + 6'(i), (i != 0) ? 8'hF8 : 8'h9E);
      poll(IDX_STS_A + 6'(i), 8'hFF, 8'h00, 1, "status written");
      poll(cfg_idx[i], 8'hFF, 8'h00, 1, "cfg reset");
      poll(low_idx[i], 8'hFF, 8'h00, 1, "low reset");
    end
    apb(1'b0, 8'h00, 8'h00, v, e);
    `CHK({e, v}, 9'h100, "unmapped read")
    apb(1'b0, 8'hE1, 8'h00, v, e);
    `CHK(e, 1'b1, "unaligned read")
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      wr(IDX_CTRL_CFG, 8'h18);
      for (int m = 0; m < 4; m++) begin
        wr(cfg_idx[p], {m[1], m[0], 6'h00});
        wr(low_idx[p], 8'h04);
        fs_per(p, dt, lvl);
        ex = m[1] ? 800 : 1600;
        `CHK(fs_oe[p], 1'b1, "sync not driven")
        `CHK(dt >= ex - 50 && dt <= ex + 50, 1'b1, "frame period")
        if (!m[1]) `CHK(lvl, ~m[0], "sync edge polarity")
      end
      wr(cfg_idx[p], 8'hC1);
      poll(cfg_idx[p], 8'hFF, 8'hC1, 1, "cfg readback");
      fs_per(p, dt, lvl);
      `CHK(dt, 52000, "wide ratio period")
    end
    $display("test controller done");
    wr(IDX_CTRL_CFG, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(cfg_idx[p], 8'h00);
      wr(low_idx[p], 8'h08);
    end
    @(posedge mclk);
    `CHK({fs_oe, fs_out}, 4'h0, "target drives sync")
    poll(IDX_STS_B, 8'hF8, 8'h00, 200, "target clean");
    for (int p = 0; p < 2; p++) begin
      wr(low_idx[p], 8'h09);
      poll(IDX_STS_B, rat_m[p], rat_m[p], 200, "ratio flag");
      poll(IDX_STS_A, 8'h80, 8'h80, 4, "proc flag");
      wr(low_idx[p], 8'h08);
      poll(IDX_STS_B, 8'hF8, 8'h00, 200, "ratio clear");
      @(posedge mclk);
      fs_run[p] <= 1'b0;
      poll(IDX_STS_B, rate_m[p], rate_m[p], 200, "halt flag");
      fs_run[p] <= 1'b1;
      poll(IDX_STS_B, 8'hF8, 8'h00, 200, "rate clear");
    end
    ref_run <= 1'b0;
    poll(IDX_STS_B, 8'h20, 8'h20, 200, "ref flag");
    poll(IDX_STS_A, 8'h80, 8'h80, 4, "proc flag ref");
    ref_run <= 1'b1;
    poll(IDX_STS_B, 8'hF8, 8'h00, 200, "ref clear");
    poll(IDX_STS_A, 8'h80, 8'h00, 4, "proc clear");
    $display("test target done");
    @(posedge mclk);
    aud_run <= 1'b0;
    poll(IDX_STS_A, 8'h02, 8'h00, 1, "stop too early");
    poll(IDX_STS_A, 8'h02, 8'h02, 40, "stop flag");
    aud_run <= 1'b1;
    poll(IDX_STS_A, 8'h02, 8'h00, 4, "stop clear");
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      {conv_bad, custom, match_bad, pdm_bad} <= fv[k];
      poll(IDX_STS_A, 8'h1C, fe[k], 4, "fault flag");
    end
    $display("test status done");
    test_done();
  end
endmodule : tb_afc_frame_clk_mon
